// file: verilog/tccc_pkg.sv
// Package for the two-channel timer capture/compare block.
// Assumes an 8-bit register port with the printed byte offsets.
package tccc_pkg;
    // Register offsets (byte addresses on the 8-bit register port)
    localparam logic [7:0] ADDR_CH0_CS = 8'h14;
    localparam logic [7:0] ADDR_CH0_HI = 8'h15;
    localparam logic [7:0] ADDR_CH0_LO = 8'h16;
    localparam logic [7:0] ADDR_CH1_CS = 8'h17;
    localparam logic [7:0] ADDR_CH1_HI = 8'h18;
    localparam logic [7:0] ADDR_CH1_LO = 8'h19;
    // Control/status bit positions
    localparam int BIT_FLAG = 7;
    localparam int BIT_IE = 6;
    localparam int BIT_MSB = 5;
    localparam int BIT_MSA = 4;
    localparam int BIT_ELSB = 3;
    localparam int BIT_ELSA = 2;
    localparam int BIT_TOV = 1;
    localparam int BIT_MAX = 0;
    // Edge/level field codes
    localparam logic [1:0] ELS_PRESET = 2'b00;
    localparam logic [1:0] ELS_RISE_TOG = 2'b01;
    localparam logic [1:0] ELS_FALL_CLR = 2'b10;
    localparam logic [1:0] ELS_ANY_SET = 2'b11;
    localparam logic [7:0] CS_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Control/status fields of one channel
    typedef struct packed {
        logic flag;
        logic irq_en;
        logic buf_sel;
        logic mode_a;
        logic [1:0] els;
        logic tov;
        logic max_duty;
    } tccc_cs_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tccc_req_t;
endpackage

// file: verilog/tccc_top.sv
// Two timer channels (capture, compare, PWM) on a shared 16-bit counter.
// Assumes counter value, overflow pulse come from the timer core and the
// channel pins are synchronous to ref_clk_i.
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// RULE1 - Capture mode sets the event flag on the selected pin edge.
// RULE2 - Compare mode sets the event flag when counter equals channel value.
// RULE3 - Flag clears by status read with flag set, then writing zero.
// RULE4 - A new event between read and clearing write keeps the flag set.
// RULE5 - Writing one to the flag does nothing; reset clears flag and enable.
// RULE6 - Interrupt request is enable AND flag; here channel 1 request is also held low while channel 0 runs buffered.
// RULE7 - Buffered select only on channel 0; it disables channel 1 register and pin.
// RULE8 - Field nonzero: mode A one selects compare/PWM, zero selects capture.
// RULE9 - Field zero is output preset; mode A one gives low, zero high.
// RULE10 - Capture edges: 01 rising, 10 falling, 11 either.
// RULE11 - Compare action: 01 toggles, 10 drives low, 11 drives high.
// RULE12 - Software stops and resets counter before changing mode bits.
// RULE13 - External pin stays stable two clocks before capture is enabled.
// RULE14 - Toggle-on-overflow toggles the compare pin on overflow; not in capture.
// RULE15 - Overflow action wins over a simultaneous compare when toggle set.
// RULE16 - Max-duty forces PWM to full duty when toggle-on-overflow clear.
// RULE17 - Max-duty changes take effect from the next PWM period.
// RULE18 - Value registers hold capture or compare value; undefined after reset.
// RULE19 - Capture: high byte read blocks captures until low byte read.
// RULE20 - Compare: high byte write blocks compares until low byte write.
// RULE21 - Counter overflow pulse marks modulo reached and drives toggling.
// RULE22 - Only channel 0 pin serves buffered output; others independent.
// RULE23 - Buffered mode alternates active value register at period boundaries.
module tccc_top #(
    parameter int CNT_W = 16
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic [CNT_W-1:0] count_i,
    input wire logic overflow_i,
    input wire logic [1:0] pin_in_i,
    output logic [1:0] pin_out_o,
    output logic [1:0] pin_oe_o,
    output logic [1:0] irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // Register state
    tccc_pkg::tccc_cs_t cs_q [2];
    logic [CNT_W-1:0] val_q [2];
    logic [7:0] hi_buf_q [2];
    logic [1:0] armed_q;
    logic [1:0] cap_blk_q;
    logic [1:0] cmp_blk_q;
    logic [1:0] pin_q;
    logic [1:0] pin_prev_q;
    logic [1:0] max_eff_q;
    logic sel1_q;
    logic [7:0] rdata_q;
    tccc_pkg::tccc_req_t req;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // Address decode; channel 1 status register vanishes in buffered mode
    wire buf_on = cs_q[0].buf_sel; // [RULE7]
    wire [1:0] hit_cs;
    wire [1:0] hit_hi;
    wire [1:0] hit_lo;
    assign hit_cs[0] = req.addr == tccc_pkg::ADDR_CH0_CS;
    assign hit_hi[0] = req.addr == tccc_pkg::ADDR_CH0_HI;
    assign hit_lo[0] = req.addr == tccc_pkg::ADDR_CH0_LO;
    assign hit_cs[1] = req.addr == tccc_pkg::ADDR_CH1_CS && !buf_on; // [RULE7]
    assign hit_hi[1] = req.addr == tccc_pkg::ADDR_CH1_HI;
    assign hit_lo[1] = req.addr == tccc_pkg::ADDR_CH1_LO;

    // Per-channel mode decode
    wire [1:0] is_preset;
    wire [1:0] is_capture;
    wire [1:0] is_compare;
    wire [1:0] ch_active;
    wire [1:0] edge_hit;
    wire [1:0] match;
    wire [1:0] event_set;
    wire [1:0] flag_clr;
    wire [1:0] period_end;
    wire [CNT_W-1:0] cmp_val [2];

    // Channel 1 is dead while channel 0 runs buffered
    assign ch_active[0] = 1'b1;
    assign ch_active[1] = !buf_on; // [RULE7] [RULE22]
    // In buffered mode the active value alternates between the two registers
    assign cmp_val[0] = (buf_on && sel1_q) ? val_q[1] : val_q[0]; // [RULE23]
    assign cmp_val[1] = val_q[1];

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            wire [1:0] els = cs_q[g].els;
            wire mode_b = (g == 0) ? cs_q[0].buf_sel : 1'b0;
            assign is_preset[g] = els == tccc_pkg::ELS_PRESET; // [RULE9]
            // Mode A selects compare/PWM versus capture
            assign is_capture[g] = !is_preset[g] && !mode_b
                && !cs_q[g].mode_a; // [RULE8]
            assign is_compare[g] = !is_preset[g]
                && (mode_b || cs_q[g].mode_a); // [RULE8]
            // Edge select
            assign edge_hit[g] = is_capture[g] && (
                (els[0] && pin_in_i[g] && !pin_prev_q[g]) ||
                (els[1] && !pin_in_i[g] && pin_prev_q[g])); // [RULE10]
            assign match[g] = is_compare[g] && !cmp_blk_q[g]
                && count_i == cmp_val[g]; // [RULE2] [RULE20]
            assign event_set[g] = ch_active[g] && ((edge_hit[g]
                && !cap_blk_q[g]) || match[g]); // [RULE1] [RULE19]
            // Clearing write of zero after an armed read
            assign flag_clr[g] = req.wr && hit_cs[g] && armed_q[g]
                && !req.wdata[tccc_pkg::BIT_FLAG]; // [RULE3] [RULE5]
            assign period_end[g] = overflow_i;
            assign irq_o[g] = cs_q[g].irq_en && cs_q[g].flag
                && ch_active[g]; // [RULE6]
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Control/status registers and clear sequence
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_q[0] <= tccc_pkg::CS_RESET; // [RULE5]
            cs_q[1] <= tccc_pkg::CS_RESET;
            armed_q <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (req.wr && hit_cs[i]) begin
                    cs_q[i].irq_en <= req.wdata[tccc_pkg::BIT_IE];
                    cs_q[i].buf_sel <= (i == 0)
                        ? req.wdata[tccc_pkg::BIT_MSB] : 1'b0; // [RULE7]
                    cs_q[i].mode_a <= req.wdata[tccc_pkg::BIT_MSA];
                    cs_q[i].els <= req.wdata[tccc_pkg::BIT_ELSB:
                        tccc_pkg::BIT_ELSA];
                    cs_q[i].tov <= req.wdata[tccc_pkg::BIT_TOV];
                    cs_q[i].max_duty <= req.wdata[tccc_pkg::BIT_MAX];
                end
                // Set wins over clear; a fresh event disarms the clear
                if (event_set[i]) begin
                    cs_q[i].flag <= 1'b1; // [RULE4]
                end else if (flag_clr[i]) begin
                    cs_q[i].flag <= 1'b0; // [RULE3]
                end
                if (event_set[i] || (req.wr && hit_cs[i])) begin
                    armed_q[i] <= 1'b0; // [RULE4]
                end else if (req.rd && hit_cs[i] && cs_q[i].flag) begin
                    armed_q[i] <= 1'b1; // [RULE3]
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Value registers, capture and byte-pair locks
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cap_blk_q <= 2'b00;
            cmp_blk_q <= 2'b00;
            hi_buf_q[0] <= tccc_pkg::BYTE_ZERO;
            hi_buf_q[1] <= tccc_pkg::BYTE_ZERO;
            val_q[0] <= '0; // Contents are not meaningful after reset
            val_q[1] <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (edge_hit[i] && !cap_blk_q[i] && ch_active[i]) begin
                    val_q[i] <= count_i; // [RULE18]
                end
                if (is_capture[i] && req.rd && hit_hi[i]) begin
                    cap_blk_q[i] <= 1'b1; // [RULE19]
                end else if (req.rd && hit_lo[i]) begin
                    cap_blk_q[i] <= 1'b0;
                end
                // High byte held until the low byte completes the pair
                if (req.wr && hit_hi[i]) begin
                    hi_buf_q[i] <= req.wdata;
                    cmp_blk_q[i] <= is_compare[i]; // [RULE20]
                end else if (req.wr && hit_lo[i]) begin
                    // Cast keeps the pair legal if the counter is narrower
                    val_q[i] <= CNT_W'({hi_buf_q[i], req.wdata}); // [RULE18]
                    cmp_blk_q[i] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive, overflow toggle and max duty
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_q <= 2'b00;
            pin_prev_q <= 2'b00;
            max_eff_q <= 2'b00;
            sel1_q <= 1'b0;
        end else begin
            pin_prev_q <= pin_in_i;
            if (buf_on && period_end[0]) begin
                sel1_q <= !sel1_q; // [RULE23]
            end else if (!buf_on) begin
                sel1_q <= 1'b0;
            end
            for (int i = 0; i < 2; i++) begin
                // Max duty only latches at a period boundary
                if (period_end[i]) begin
                    max_eff_q[i] <= cs_q[i].max_duty; // [RULE17]
                end
                if (is_preset[i]) begin
                    pin_q[i] <= !cs_q[i].mode_a; // [RULE9]
                end else if (is_compare[i] && ch_active[i]) begin
                    if (cs_q[i].tov && overflow_i) begin
                        pin_q[i] <= !pin_q[i]; // [RULE14] [RULE15] [RULE21]
                    end else if (match[i]) begin
                        case (cs_q[i].els)
                            tccc_pkg::ELS_RISE_TOG: pin_q[i] <= !pin_q[i];
                            tccc_pkg::ELS_FALL_CLR: pin_q[i] <= 1'b0;
                            tccc_pkg::ELS_ANY_SET: pin_q[i] <= 1'b1;
                            default: pin_q[i] <= pin_q[i];
                        endcase // [RULE11]
                    end
                end
            end
        end
    end

    // Full duty holds the pin at its set-on-compare level, since the
    // compare in that period would otherwise end the active phase
    generate
        for (g = 0; g < 2; g++) begin : g_pin
            wire force_full = max_eff_q[g] && !cs_q[g].tov
                && is_compare[g]; // [RULE16]
            assign pin_out_o[g] = force_full
                ? (cs_q[g].els != tccc_pkg::ELS_FALL_CLR) : pin_q[g];
            assign pin_oe_o[g] = ch_active[g]
                && (is_compare[g] || is_preset[g]); // [RULE22]
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = tccc_pkg::BYTE_ZERO;
        for (int i = 0; i < 2; i++) begin
            if (hit_cs[i]) begin
                rd_mux = cs_q[i];
            end
            if (hit_hi[i]) begin
                rd_mux = val_q[i][CNT_W-1 -: 8];
            end
            if (hit_lo[i]) begin
                rd_mux = val_q[i][7:0];
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= tccc_pkg::BYTE_ZERO;
        end else begin
            rdata_q <= req.rd ? rd_mux : tccc_pkg::BYTE_ZERO;
        end
    end
    assign rdata_o = rdata_q;

endmodule
`default_nettype wire

// file: tb/tccc_top_asserts.sv
// Checker for the two-channel capture/compare block, channel 0 side.
// Sees only top ports; channel 0 setup is shadowed from bus writes.
`timescale 1ns/10ps
`default_nettype none
module tccc_chk #(
    parameter int CNT_W = 16
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [CNT_W-1:0] count_i,
    input wire logic overflow_i,
    input wire logic [1:0] pin_in_i,
    input wire logic [1:0] pin_out_o,
    input wire logic [1:0] pin_oe_o,
    input wire logic [1:0] irq_o
);
    logic [6:0] cs_q;
    logic [7:0] hi_q;
    logic [CNT_W-1:0] val_q;
    logic hb_q;
    logic mx_q;
    // Mode decode; the byte lock follows reads in capture, writes otherwise
    wire logic cmp = cs_q[4] && !cs_q[5] && cs_q[3:2] != 2'b00;
    wire logic cap = !cs_q[4] && !cs_q[5] && cs_q[3:2] != 2'b00;
    wire logic acc = cap ? rd_i : wr_i;
    wire logic hit = !hb_q && count_i == val_q;
    //////////////////////////////////////////////////////////////////////
    // Shadow state; flag is left out since only the design knows events
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_q <= '0;
            hi_q <= '0;
            val_q <= '0;
            hb_q <= 1'b0;
            mx_q <= 1'b0;
        end else begin
            if (wr_i && addr_i == tccc_pkg::ADDR_CH0_CS)
                cs_q <= wdata_i[6:0];
            if (wr_i && addr_i == tccc_pkg::ADDR_CH0_HI)
                hi_q <= wdata_i;
            if (wr_i && addr_i == tccc_pkg::ADDR_CH0_LO)
                val_q <= CNT_W'({hi_q, wdata_i});
            if (acc && addr_i == tccc_pkg::ADDR_CH0_HI)
                hb_q <= 1'b1;
            if (acc && addr_i == tccc_pkg::ADDR_CH0_LO)
                hb_q <= 1'b0;
            if (overflow_i)
                mx_q <= cs_q[0];
        end
    end
    //////////////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    AST_CH1_OFF: assert property (
        rd_i && addr_i == 8'h17 && cs_q[5] |=> rdata_o == 8'h00)
        else $error("channel 1 status readable in buffered mode");
    AST_IRQ_EN: assert property (!cs_q[6] |-> !irq_o[0])
        else $error("request raised while disabled");
    AST_W1: assert property (
        irq_o[0] && wr_i && addr_i == 8'h14 && wdata_i[7:6] == 2'b11
        |=> irq_o[0]) else $error("writing one dropped the flag");
    AST_CAP: assert property (
        cap && cs_q[6] && !hb_q && ((cs_q[2] && $rose(pin_in_i[0])) ||
        (cs_q[3] && $fell(pin_in_i[0]))) |-> ##[1:2] irq_o[0])
        else $error("active edge not flagged");
    AST_CMP_LVL: assert property (
        cmp && cs_q[3] && !cs_q[1] && !mx_q && !overflow_i && hit
        |=> pin_out_o[0] == $past(cs_q[2]))
        else $error("compare action level wrong");
    AST_CMP_FLAG: assert property (cmp && cs_q[6] && hit |=> irq_o[0])
        else $error("compare match not flagged");
    AST_TOV: assert property (
        cmp && cs_q[1] && overflow_i
        |=> pin_out_o[0] != $past(pin_out_o[0]))
        else $error("pin did not toggle on overflow");
    AST_PRESET: assert property (
        $past(rst_n_i) && $stable(cs_q[4:2]) && cs_q[3:2] == 2'b00
        |-> pin_oe_o[0] && pin_out_o[0] == !cs_q[4])
        else $error("preset level wrong");
    AST_MAX: assert property (
        mx_q && cmp && !cs_q[1] && cs_q[3:2] != 2'b10 |-> pin_out_o[0])
        else $error("full duty not forced");
endmodule
bind tccc_top tccc_chk #(.CNT_W(CNT_W)) chk_u (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .count_i(count_i),
    .overflow_i(overflow_i), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o), .irq_o(irq_o));
`default_nettype wire

// file: tb/tccc_pins.sv
// Outside drivers of the two channel pins.
// Assumes the bench asks for levels; the wire resolves against the block.
`timescale 1ns/10ps
`default_nettype none
module tccc_pins (
    input wire logic ref_clk_i,
    input wire logic [1:0] lvl_i,
    input wire logic [1:0] pin_out_i,
    input wire logic [1:0] pin_oe_i,
    output logic [1:0] pin_o
);
    logic [1:0] lvl_q = 2'b11;
    // Levels move a cycle late and only on an edge, so they stay steady
    // for the settle time the bench allows before capture
    always @(posedge ref_clk_i)
        lvl_q <= lvl_i;
    // The block wins the wire whenever it drives
    assign pin_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & lvl_q);
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the two-channel capture/compare block.
// Assumes the checker binds itself; the bench plays counter, bus, pins.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [15:0] count_i = 16'hffff;
    logic overflow_i = 1'b0;
    logic [1:0] lvl = 2'b11;
    logic [1:0] pin_in, pin_out, pin_oe, irq;
    logic [7:0] rdata;
    logic [1:0] e;
    logic p;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    always #10 ref_clk_i = ~ref_clk_i;
    tccc_top #(.CNT_W(16)) dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata), .count_i(count_i), .overflow_i(overflow_i),
        .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
        .irq_o(irq));
    tccc_pins pins_u (.ref_clk_i(ref_clk_i), .lvl_i(lvl),
        .pin_out_i(pin_out), .pin_oe_i(pin_oe), .pin_o(pin_in));
    //////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [15:0] x, g);
        n_checks++;
        if (g !== x) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, x, g);
        end
    endtask
    // Strobe tasks leave a idle cycle so no strobe is set twice in a step
    task automatic w(input logic [7:0] a, d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic r(input logic [7:0] a, x);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        @(negedge ref_clk_i);
        chk($sformatf("reg %h", a), x, rdata);
        @(posedge ref_clk_i);
    endtask
    // Counter value and overflow pulse for one cycle
    task automatic ev(input logic [15:0] v, input logic o);
        count_i <= v;
        overflow_i <= o;
        @(posedge ref_clk_i);
        count_i <= 16'hffff;
        overflow_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
    endtask
    task automatic pn(input logic [1:0] l);
        lvl <= l;
        repeat (4) @(posedge ref_clk_i);
    endtask
    // Sample away from the launching edge
    task automatic pc(input logic [3:0] m, x);
        @(negedge ref_clk_i);
        chk("irq_pin", x, {irq, pin_out} & m);
        @(posedge ref_clk_i);
    endtask
    task automatic rst_seq;
        rst_n_i <= 1'b0;
        repeat (10) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        @(posedge ref_clk_i);
    endtask
    //////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        r(8'h14, 8'h00);
        r(8'h30, 8'h00);
        pc(4'h1, 4'h1);
        w(8'h14, 8'h80);
        r(8'h14, 8'h00);
        w(8'h14, 8'h10);
        pc(4'h1, 4'h0);
    endtask
    // Preset high first: the pin then reads high before and after capture
    // is enabled, so no stray edge is seen
    task automatic t_capture;
        w(8'h14, 8'h00);
        count_i <= 16'h1a2b;
        for (int i = 1; i < 4; i++) begin
            e = 2'(i);
            w(8'h14, {4'h4, e, 2'b00});
            pn(2'b10);
            r(8'h14, {e[1], 3'h4, e, 2'b00});
            w(8'h14, {4'h4, e, 2'b00});
            pn(2'b11);
            r(8'h15, 8'h1a);
            r(8'h16, 8'h2b);
            r(8'h14, {e[0], 3'h4, e, 2'b00});
            w(8'h14, 8'h00);
        end
    endtask
    task automatic t_race;
        w(8'h14, 8'h44);
        pn(2'b10);
        pn(2'b11);
        r(8'h14, 8'hc4);
        pc(4'h4, 4'h4);
        w(8'h14, 8'hc4);
        r(8'h14, 8'hc4);
        pn(2'b10);
        pn(2'b11);
        w(8'h14, 8'h44);
        r(8'h14, 8'hc4);
        w(8'h14, 8'h44);
        r(8'h14, 8'h44);
        w(8'h14, 8'h04);
        count_i <= 16'h1111;
        pn(2'b10);
        pn(2'b11);
        pc(4'h4, 4'h0);
        r(8'h15, 8'h11);
        count_i <= 16'h2222;
        pn(2'b10);
        pn(2'b11);
        r(8'h16, 8'h11);
        count_i <= 16'hffff;
        r(8'h14, 8'h84);
        w(8'h14, 8'h00);
    endtask
    task automatic t_compare;
        p = 1'b1;
        for (int i = 1; i < 4; i++) begin
            e = 2'(i);
            w(8'h14, {4'h5, e, 2'b00});
            w(8'h15, 8'h12);
            w(8'h16, 8'h34);
            ev(16'h1234, 1'b0);
            p = (e == 2'b01) ? ~p : e[0];
            pc(4'h5, {3'b010, p});
            r(8'h14, {1'b1, 3'h5, e, 2'b00});
            w(8'h14, {4'h5, e, 2'b00});
        end
        w(8'h15, 8'h12);
        ev(16'h1234, 1'b0);
        r(8'h14, 8'h5c);
        w(8'h16, 8'h34);
    endtask
    task automatic t_tov_max;
        // Set-on-compare, so only the overflow toggle can give low here
        w(8'h14, 8'h1e);
        ev(16'h1234, 1'b1);
        pc(4'h1, 4'h0);
        ev(16'hffff, 1'b1);
        pc(4'h1, 4'h1);
        w(8'h14, 8'h15);
        ev(16'h1234, 1'b0);
        pc(4'h1, 4'h0);
        ev(16'hffff, 1'b1);
        pc(4'h1, 4'h1);
        ev(16'h1234, 1'b0);
        pc(4'h1, 4'h1);
        w(8'h14, 8'h14);
        ev(16'h1234, 1'b0);
        pc(4'h1, 4'h1);
    endtask
    // Fresh reset so the value alternation starts from channel 0
    task automatic t_buf;
        rst_seq;
        w(8'h15, 8'h01);
        w(8'h16, 8'h00);
        w(8'h18, 8'h02);
        w(8'h19, 8'h00);
        w(8'h14, 8'h34);
        r(8'h17, 8'h00);
        w(8'h17, 8'h44);
        r(8'h17, 8'h00);
        @(negedge ref_clk_i);
        chk("pin_oe", 16'h0001, pin_oe);
        @(posedge ref_clk_i);
        ev(16'h0200, 1'b0);
        pc(4'h1, 4'h1);
        ev(16'h0100, 1'b0);
        pc(4'h1, 4'h0);
        ev(16'hffff, 1'b1);
        ev(16'h0100, 1'b0);
        pc(4'h1, 4'h0);
        ev(16'h0200, 1'b0);
        pc(4'h1, 4'h1);
    endtask
    //////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Cycle ceiling well above the few hundred cycles the run needs
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish;
        end
    end
    initial begin
        rst_seq;
        t_reset;
        t_capture;
        t_race;
        t_compare;
        t_tov_max;
        t_buf;
        tally_and_finish;
    end
endmodule
`default_nettype wire
